//--- core/uvp_stages.sv
// Purpose: Three-stage definite-time undervoltage protection
// Assumes: Voltages arrive synchronous, in 0.1 % Un steps
// Notes:   Registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module uvp_stages #(
  parameter int MS_CYCLES = uvp_pkg::MS_CYCLES,
  parameter int FORCE_MS = uvp_pkg::FORCE_MS,
  parameter logic [31:0] PASSWORD_KEY = 32'h00c0ffee // Arbitrary value
) (
  // Clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_reset,
  // Measurements and external signals
  input  wire uvp_pkg::uvp_volts_type i_volts,
  input  wire logic [2:0]             i_block,
  input  wire logic [31:0]            i_group_signals,
  // Register port
  input  wire logic [7:0]             i_address,
  input  wire logic [31:0]            i_write_data,
  input  wire logic                   i_write,
  input  wire logic                   i_read,
  output logic [31:0]                 o_read_data,
  // Protection outputs
  output logic [2:0]                  o_start,
  output logic [2:0]                  o_trip,
  output logic                        o_irq
);
  localparam int S = uvp_pkg::STAGES;
  localparam int G = uvp_pkg::GROUPS;

  if (MS_CYCLES < 1 || MS_CYCLES > 131071) begin : g_ms_check
    $error("MS_CYCLES out of range");
  end
  if (FORCE_MS < 1 || FORCE_MS > 524287) begin : g_force_check
    $error("FORCE_MS out of range");
  end

  function automatic logic [15:0] min3(input uvp_pkg::uvp_volts_type v);
    logic [15:0] m;
    m = (v.ab < v.bc) ? v.ab : v.bc;
    return (v.ca < m) ? v.ca : m;
  endfunction

  function automatic logic [31:0] to_primary(input logic [15:0] pu,
                                             input logic [15:0] nom);
    logic [31:0] prod;
    prod = pu * nom;
    return prod / 32'd1000;
  endfunction

  // Time base
  logic [16:0]                  ms_count, next_ms_count;
  logic                         ms_tick;

  // Software state
  logic                         unlocked, next_unlocked;
  logic                         force_on, next_force_on;
  logic [2:0]                   forced_start, next_forced_start;
  logic [2:0]                   forced_trip, next_forced_trip;
  logic [18:0]                  force_ms, next_force_ms;
  logic [2:0]                   manual_group, next_manual_group;
  logic [2:0]                   switched_group, next_switched_group;
  logic [4:0]                   group_source, next_group_source;
  logic [15:0]                  dead_band, next_dead_band;
  logic [15:0]                  release_delay, next_release_delay;
  logic [15:0]                  nominal_volts, next_nominal_volts;
  logic [uvp_pkg::IRQ_BITS-1:0] irq_status, next_irq_status;
  logic [uvp_pkg::IRQ_BITS-1:0] irq_mask, next_irq_mask;
  logic [15:0]                  start_count [S], next_start_count [S];
  logic [15:0]                  trip_count [S], next_trip_count [S];
  logic [31:0]                  read_data, next_read_data;
  uvp_pkg::uvp_setting_type     setting [S*G], next_setting [S*G];

  // Stage state
  uvp_pkg::uvp_state_type       state [S], next_state [S];
  logic [15:0]                  timer [S], next_timer [S];
  logic [15:0]                  rel_count [S], next_rel_count [S];
  logic [2:0]                   start_out, next_start_out;
  logic [2:0]                   trip_out, next_trip_out;
  logic [2:0]                   blocked;
  logic [2:0]                   under;
  logic [2:0]                   released;
  logic [15:0]                  cur_delay [S];
  logic [15:0]                  cur_limit [S];
  logic [1:0]                   active;
  logic [15:0]                  vmin;
  logic [15:0]                  vmax;

  assign ms_tick = (ms_count == 17'(MS_CYCLES - 1));
  assign vmin = min3(i_volts);
  assign vmax = 16'hffff - min3(~i_volts);
  assign o_start = start_out;
  assign o_trip = trip_out;
  assign o_irq = |(irq_status & irq_mask);
  assign o_read_data = read_data;

  // Active group: selected signal picks the switched group
  always_comb begin
    if (group_source != 5'h00 && i_group_signals[group_source - 5'h01])
      active = 2'(switched_group - 3'h1);
    else
      active = 2'(manual_group - 3'h1);
  end

  always_comb begin
    uvp_pkg::uvp_setting_type cur;
    logic [15:0]              rel_limit;
    logic [31:0]              band;
    cur = '0;
    rel_limit = 16'h0000;
    band = 32'h0;
    for (int s = 0; s < S; s++) begin
      cur = setting[s*G + int'(active)];
      cur_delay[s] = cur.delay_ms;
      cur_limit[s] = cur.block_limit;
      rel_limit = (s == 0) ? release_delay : 16'h0000;
      band = (cur.pickup * dead_band) / 32'd1000;
      blocked[s] = i_block[s]
        | (cur.block_limit != 16'h0000 && vmax < cur.block_limit);
      under[s] = vmin < cur.pickup;
      released[s] = {16'h0, vmin} > {16'h0, cur.pickup} + band;
      next_state[s] = state[s];
      next_timer[s] = timer[s];
      next_rel_count[s] = rel_count[s];
      if (blocked[s]) begin
        next_state[s] = uvp_pkg::ST_BLOCKED;
        next_timer[s] = 16'h0000;
        next_rel_count[s] = 16'h0000;
      end else begin
        case (state[s])
          // Leaving blocked keeps no memory of it
          uvp_pkg::ST_IDLE, uvp_pkg::ST_BLOCKED: begin
            next_timer[s] = 16'h0000;
            next_rel_count[s] = 16'h0000;
            next_state[s] = under[s] ? uvp_pkg::ST_START : uvp_pkg::ST_IDLE;
          end
          uvp_pkg::ST_START, uvp_pkg::ST_TRIP: begin
            if (released[s]) begin
              next_timer[s] = 16'h0000;
              if (rel_count[s] >= rel_limit) begin
                next_state[s] = uvp_pkg::ST_IDLE;
                next_rel_count[s] = 16'h0000;
              end else if (ms_tick) begin
                next_rel_count[s] = rel_count[s] + 16'h0001;
              end
            end else begin
              next_rel_count[s] = 16'h0000;
              if (state[s] == uvp_pkg::ST_START) begin
                if (timer[s] >= cur.delay_ms)
                  next_state[s] = uvp_pkg::ST_TRIP;
                else if (ms_tick)
                  next_timer[s] = timer[s] + 16'h0001;
              end
            end
          end
          default: next_state[s] = uvp_pkg::ST_IDLE;
        endcase
      end
      next_start_out[s] = force_on ? forced_start[s]
                                   : state[s][1];
      next_trip_out[s] = force_on ? forced_trip[s]
                                  : (state[s] == uvp_pkg::ST_TRIP);
    end
  end

  always_ff @(posedge i_clock) begin
    for (int s = 0; s < S; s++) begin
      if (i_reset) begin
        state[s] <= uvp_pkg::ST_IDLE;
        timer[s] <= 16'h0000;
        rel_count[s] <= 16'h0000;
      end else begin
        state[s] <= next_state[s];
        timer[s] <= next_timer[s];
        rel_count[s] <= next_rel_count[s];
      end
    end
    if (i_reset) begin
      start_out <= 3'h0;
      trip_out <= 3'h0;
      ms_count <= 17'h0;
    end else begin
      start_out <= next_start_out;
      trip_out <= next_trip_out;
      ms_count <= next_ms_count;
    end
  end

  // Register port and software state
  always_comb begin
    logic       wr;
    logic       cfg;
    logic [3:0] idx;
    logic [2:0] st_rise;
    logic [2:0] tr_rise;
    wr = i_write;
    cfg = i_write & unlocked;
    idx = i_address[5:2];
    st_rise = next_start_out & ~start_out;
    tr_rise = next_trip_out & ~trip_out;
    next_ms_count = ms_tick ? 17'h0 : ms_count + 17'h1;
    next_unlocked = unlocked;
    next_force_on = force_on;
    next_forced_start = forced_start;
    next_forced_trip = forced_trip;
    next_force_ms = force_ms;
    next_manual_group = manual_group;
    next_switched_group = switched_group;
    next_group_source = group_source;
    next_dead_band = dead_band;
    next_release_delay = release_delay;
    next_nominal_volts = nominal_volts;
    next_irq_mask = irq_mask;
    next_setting = setting;
    next_irq_status = irq_status;
    next_read_data = 32'h0;
    if (wr && i_address == uvp_pkg::OFS_PASSWORD)
      next_unlocked = (i_write_data == PASSWORD_KEY);
    if (wr && i_address == uvp_pkg::OFS_IRQ_STATUS)
      next_irq_status = irq_status & ~i_write_data[uvp_pkg::IRQ_BITS-1:0];
    if (wr && i_address == uvp_pkg::OFS_IRQ_MASK)
      next_irq_mask = i_write_data[uvp_pkg::IRQ_BITS-1:0];
    if (force_on && ms_tick)
      next_force_ms = force_ms + 19'h1;
    if (force_on && force_ms >= 19'(FORCE_MS)) begin
      next_force_on = 1'b0;
      next_irq_status[uvp_pkg::IRQ_FORCE_END] = 1'b1;
    end
    if (cfg && i_address == uvp_pkg::OFS_FORCE) begin
      next_force_on = i_write_data[uvp_pkg::FORCE_BIT];
      next_force_ms = 19'h0;
    end
    if (wr && force_on && i_address == uvp_pkg::OFS_FORCE) begin
      next_forced_start = i_write_data[uvp_pkg::FORCED_START_LSB +: 3];
      next_forced_trip = i_write_data[uvp_pkg::FORCED_TRIP_LSB +: 3];
    end
    if (!next_force_on) begin
      next_forced_start = 3'h0;
      next_forced_trip = 3'h0;
    end
    if (cfg && i_address == uvp_pkg::OFS_GROUP) begin
      if (i_write_data[2:0] >= 3'h1 && i_write_data[2:0] <= 3'h4)
        next_manual_group = i_write_data[2:0];
      if (i_write_data[6:4] >= 3'h1 && i_write_data[6:4] <= 3'h4)
        next_switched_group = i_write_data[6:4];
      next_group_source = i_write_data[uvp_pkg::SOURCE_LSB +: 5];
    end
    if (cfg && i_address == uvp_pkg::OFS_DEAD_BAND)
      next_dead_band = i_write_data[15:0];
    if (cfg && i_address == uvp_pkg::OFS_RELEASE)
      next_release_delay = i_write_data[15:0];
    if (cfg && i_address == uvp_pkg::OFS_NOMINAL)
      next_nominal_volts = i_write_data[15:0];
    if (cfg && idx[3:2] != 2'h3 && i_address[7:6] == uvp_pkg::PAGE_LEVELS)
    begin
      next_setting[idx].pickup = i_write_data[15:0];
      next_setting[idx].block_limit = i_write_data[31:16];
    end
    if (cfg && idx[3:2] != 2'h3 && i_address[7:6] == uvp_pkg::PAGE_DELAY)
      next_setting[idx].delay_ms = i_write_data[15:0];
    for (int s = 0; s < S; s++) begin
      next_start_count[s] = start_count[s];
      next_trip_count[s] = trip_count[s];
      if (wr && i_address == uvp_pkg::OFS_COUNT_CLEAR) begin
        if (i_write_data[s]) next_start_count[s] = 16'h0000;
        if (i_write_data[uvp_pkg::TRIP_CLEAR_LSB + s])
          next_trip_count[s] = 16'h0000;
      end
      // Increment after clear so a same-cycle event is kept
      if (st_rise[s]) next_start_count[s] = next_start_count[s] + 16'h1;
      if (tr_rise[s]) next_trip_count[s] = next_trip_count[s] + 16'h1;
    end
    next_irq_status[2:0] = next_irq_status[2:0] | st_rise;
    next_irq_status[5:3] = next_irq_status[5:3] | tr_rise;
    if (i_read) begin
      case (i_address)
        uvp_pkg::OFS_PASSWORD: next_read_data = {31'h0, unlocked};
        uvp_pkg::OFS_FORCE: next_read_data = {21'h0, forced_trip, 1'b0,
                                             forced_start, 3'h0, force_on};
        uvp_pkg::OFS_GROUP: next_read_data = {14'h0, active, 3'h0,
                                             group_source, 1'b0,
                                             switched_group, 1'b0,
                                             manual_group};
        uvp_pkg::OFS_DEAD_BAND: next_read_data = {16'h0, dead_band};
        uvp_pkg::OFS_RELEASE: next_read_data = {16'h0, release_delay};
        uvp_pkg::OFS_NOMINAL: next_read_data = {16'h0, nominal_volts};
        uvp_pkg::OFS_IRQ_STATUS: next_read_data = 32'(irq_status);
        uvp_pkg::OFS_IRQ_MASK: next_read_data = 32'(irq_mask);
        uvp_pkg::OFS_STATUS: next_read_data = {26'h0, state[2],
                                              state[1], state[0]};
        uvp_pkg::OFS_MIN_VOLTS:
          next_read_data = to_primary(vmin, nominal_volts);
        default: begin
          if (i_address[7:6] == uvp_pkg::PAGE_LEVELS
              && idx[3:2] != 2'h3)
            next_read_data = {setting[idx].block_limit,
                              setting[idx].pickup};
          else if (i_address[7:6] == uvp_pkg::PAGE_DELAY
                   && idx[3:2] != 2'h3)
            next_read_data = {16'h0, setting[idx].delay_ms};
          else if (i_address[7:4] == uvp_pkg::OFS_COUNT0[7:4]
                   && idx[1:0] != 2'h3)
            next_read_data = {trip_count[idx[1:0]], start_count[idx[1:0]]};
          else if (i_address[7:4] == uvp_pkg::OFS_PICKUP_V0[7:4]
                   && idx[1:0] != 2'h3)
            next_read_data = to_primary(
              setting[int'(idx[1:0])*G + int'(active)].pickup,
              nominal_volts);
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      unlocked <= 1'b0;
      force_on <= 1'b0;
      forced_start <= 3'h0;
      forced_trip <= 3'h0;
      force_ms <= 19'h0;
      manual_group <= uvp_pkg::GROUP_RESET;
      switched_group <= uvp_pkg::GROUP_RESET;
      group_source <= 5'h00;
      dead_band <= uvp_pkg::DEAD_BAND_RESET;
      release_delay <= 16'h0000;
      nominal_volts <= uvp_pkg::NOMINAL_RESET;
      irq_status <= '0;
      irq_mask <= '0;
      read_data <= 32'h0;
      for (int i = 0; i < S*G; i++) setting[i] <= '0;
      for (int s = 0; s < S; s++) begin
        start_count[s] <= 16'h0000;
        trip_count[s] <= 16'h0000;
      end
    end else begin
      unlocked <= next_unlocked;
      force_on <= next_force_on;
      forced_start <= next_forced_start;
      forced_trip <= next_forced_trip;
      force_ms <= next_force_ms;
      manual_group <= next_manual_group;
      switched_group <= next_switched_group;
      group_source <= next_group_source;
      dead_band <= next_dead_band;
      release_delay <= next_release_delay;
      nominal_volts <= next_nominal_volts;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      read_data <= next_read_data;
      setting <= next_setting;
      start_count <= next_start_count;
      trip_count <= next_trip_count;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);

  for (genvar s = 0; s < S; s++) begin : g_checks
    start_on_under_a: assert property (
      state[s] == uvp_pkg::ST_IDLE && !blocked[s] && under[s]
      |=> state[s] == uvp_pkg::ST_START)
      else $error("stage did not start");
    trip_on_delay_a: assert property (
      state[s] == uvp_pkg::ST_START && !blocked[s] && !released[s]
      && timer[s] >= cur_delay[s] |=> state[s] == uvp_pkg::ST_TRIP)
      else $error("stage did not trip");
    block_input_a: assert property (
      i_block[s] |=> state[s] == uvp_pkg::ST_BLOCKED
      ##1 ($past(force_on) || !o_start[s]))
      else $error("blocked stage active");
    self_block_a: assert property (
      cur_limit[s] != 16'h0 && vmax < cur_limit[s]
      |=> state[s] == uvp_pkg::ST_BLOCKED)
      else $error("no self block");
    zero_limit_a: assert property (
      cur_limit[s] == 16'h0 && !i_block[s] |-> !blocked[s])
      else $error("zero limit blocked");
    count_edge_a: assert property (
      !o_start[s] && !(i_write && i_address == uvp_pkg::OFS_COUNT_CLEAR)
      ##1 o_start[s] |-> start_count[s] == $past(start_count[s]) + 16'h1)
      else $error("start count missed");
  end

  fast_release_a: assert property (
    state[1] == uvp_pkg::ST_START && released[1] && !blocked[1]
    |=> state[1] == uvp_pkg::ST_IDLE)
    else $error("stage two not released");
  force_gate_a: assert property (
    !force_on |=> forced_start == 3'h0 && forced_trip == 3'h0)
    else $error("forced bits without force");
  password_gate_a: assert property (
    !unlocked |=> $stable(dead_band) && $stable(release_delay))
    else $error("locked setting changed");
  force_timeout_a: assert property (
    force_on && force_ms >= 19'(FORCE_MS) && !i_write
    |=> !force_on ##0 irq_status[uvp_pkg::IRQ_FORCE_END])
    else $error("force not expired");

  trip_seen_c: cover property (state[0] == uvp_pkg::ST_TRIP);
  block_after_start_c: cover property (
    state[2] == uvp_pkg::ST_START ##1 state[2] == uvp_pkg::ST_BLOCKED);
  forced_trip_c: cover property (force_on && o_trip[0]);
  group_switch_c: cover property (active != $past(active));
endmodule // uvp_stages
`default_nettype wire

//--- core/uvp_pkg.sv
// Purpose: Shared constants and types of the undervoltage stage block
// Assumes: Voltages in 0.1 % Un steps, times in whole milliseconds
// Notes:   Byte addresses of the register port, one 32-bit word each
`default_nettype none
package uvp_pkg;
  localparam int STAGES = 3;
  localparam int GROUPS = 4;
  // Clock and time base
  localparam int CLOCK_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int FORCE_TIMEOUT_MIN = 5;
  localparam int FORCE_MS = FORCE_TIMEOUT_MIN * 60000;
  // Reset values
  localparam logic [15:0] DEAD_BAND_RESET = 16'h001e;
  localparam logic [2:0] GROUP_RESET = 3'h1;
  localparam logic [15:0] NOMINAL_RESET = 16'h0000;
  // Register offsets
  localparam logic [7:0] OFS_PASSWORD = 8'h00;
  localparam logic [7:0] OFS_FORCE = 8'h04;
  localparam logic [7:0] OFS_GROUP = 8'h08;
  localparam logic [7:0] OFS_DEAD_BAND = 8'h0c;
  localparam logic [7:0] OFS_RELEASE = 8'h10;
  localparam logic [7:0] OFS_NOMINAL = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_COUNT_CLEAR = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MIN_VOLTS = 8'h28;
  localparam logic [7:0] OFS_COUNT0 = 8'h30;
  localparam logic [7:0] OFS_PICKUP_V0 = 8'h40;
  localparam logic [1:0] PAGE_LEVELS = 2'h2;
  localparam logic [1:0] PAGE_DELAY = 2'h3;
  // Field positions
  localparam int FORCE_BIT = 0;
  localparam int FORCED_START_LSB = 4;
  localparam int FORCED_TRIP_LSB = 8;
  localparam int SWITCHED_LSB = 4;
  localparam int SOURCE_LSB = 8;
  localparam int ACTIVE_LSB = 16;
  localparam int TRIP_CLEAR_LSB = 4;
  localparam int IRQ_FORCE_END = 6;
  localparam int IRQ_BITS = 7;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_BLOCKED = 2'b01,
    ST_START   = 2'b10,
    ST_TRIP    = 2'b11
  } uvp_state_type;

  typedef struct packed {
    logic [15:0] delay_ms;
    logic [15:0] block_limit;
    logic [15:0] pickup;
  } uvp_setting_type;

  typedef struct packed {
    logic [15:0] ab;
    logic [15:0] bc;
    logic [15:0] ca;
  } uvp_volts_type;
endpackage
`default_nettype wire

//--- sim/uvp_front_end.sv
// Purpose: Measurement front end feeding the three line voltages
// Assumes: One fresh sample every clock, no filtering
// Notes:   Registered like a real sampler, so changes land a cycle late
`timescale 1ns/1ps
`default_nettype none
module uvp_front_end (
  // Clock
  input  wire logic              i_clock,
  // Line voltages to present
  input  wire logic [15:0]       i_ab,
  input  wire logic [15:0]       i_bc,
  input  wire logic [15:0]       i_ca,
  // Measurement bus
  output var uvp_pkg::uvp_volts_type o_volts
);
  always_ff @(posedge i_clock) begin
    o_volts <= '{ab: i_ab, bc: i_bc, ca: i_ca};
  end
endmodule // uvp_front_end
`default_nettype wire

//--- sim/undervoltage_protection_stage_bench.sv
// Purpose: Self-checking bench of the undervoltage stages
// Assumes: Short ms tick and force counts keep the run brief
// Notes:   Voltages reach the block through the front end model
`timescale 1ns/1ps
`default_nettype none
module undervoltage_protection_stage_bench;
  localparam int MS = 4;
  localparam int FMS = 20;
  localparam logic [31:0] KEY = 32'h5a5a1234; // Arbitrary value
  logic        clk, rst, wr, rd, irq;
  logic [15:0] ab, bc, ca;
  logic [2:0]  blk, st, tr;
  logic [31:0] gsig, wdat, rdat, d;
  logic [7:0]  adr;
  uvp_pkg::uvp_volts_type volts;
  int          n_mismatch, checked, n;
  uvp_front_end u_fe (.i_clock(clk), .i_ab(ab), .i_bc(bc), .i_ca(ca),
    .o_volts(volts));
  uvp_stages #(.MS_CYCLES(MS), .FORCE_MS(FMS), .PASSWORD_KEY(KEY)) u_dut (
    .i_clock(clk), .i_reset(rst), .i_volts(volts), .i_block(blk),
    .i_group_signals(gsig), .i_address(adr), .i_write_data(wdat),
    .i_write(wr), .i_read(rd), .o_read_data(rdat), .o_start(st),
    .o_trip(tr), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wdat <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    rd <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
    chk(d & m, e, "read");
  endtask
  task automatic sv(input logic [15:0] a, b, c);
    @(posedge clk);
    ab <= a;
    bc <= b;
    ca <= c;
  endtask
  // Bounded wait for start (t=0) or trip (t=1) to show e
  task automatic wo(input bit t, input logic [2:0] e, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if ((t ? tr : st) === e) return;
    end
    n_mismatch++;
    $display("BAD %0t output wait ran out", $time);
    finish_test();
  endtask
  task automatic t_setup();
    rc(8'h0c, 32'hffff, 32'h001e);
    rc(8'h08, 32'h30007, 32'h1);
    w(8'h0c, 32'h0010);
    rc(8'h0c, 32'hffff, 32'h001e);
    w(8'h00, KEY);
    rc(8'h00, 32'h1, 32'h1);
    w(8'h80, 32'h00000384);
    w(8'h90, 32'h00c801f4);
    w(8'ha0, 32'h0000012c);
    w(8'hc0, 32'h2);
    w(8'hd0, 32'h0);
    w(8'he0, 32'h1);
    w(8'h14, 32'h07d0);
    $display("test setup done");
  endtask
  task automatic t_trip();
    sv(16'h03e8, 16'h0352, 16'h03e8);
    wo(0, 3'b001, 10);
    chk({29'h0, tr}, 32'h0, "early trip");
    wo(1, 3'b001, 3 * MS + 6);
    chk(n >= MS - 1, 1, "trip delay");
    rc(8'h28, 32'hffff, 32'h06a4);
    rc(8'h40, 32'hffff, 32'h0708);
    sv(16'h03e8, 16'h0398, 16'h03e8);
    repeat (6) @(posedge clk);
    rc(8'h24, 32'h3f, 32'h3);
    w(8'h10, 32'h2);
    sv(16'h03e8, 16'h03e8, 16'h03e8);
    @(posedge clk);
    rc(8'h24, 32'h3, 32'h3);
    wo(0, 3'b000, 20);
    w(8'h10, 32'h0);
    rc(8'h30, 32'hffffffff, 32'h00010001);
    w(8'h20, 32'h11);
    rc(8'h30, 32'hffffffff, 32'h0);
    $display("test trip done");
  endtask
  task automatic t_block();
    sv(16'h03e8, 16'h0190, 16'h03e8);
    wo(0, 3'b011, 10);
    sv(16'h0096, 16'h0096, 16'h0096);
    wo(0, 3'b101, 10);
    rc(8'h24, 32'h2c, 32'h24);
    @(posedge clk);
    blk <= 3'b100;
    wo(0, 3'b001, 10);
    rc(8'h24, 32'h30, 32'h10);
    sv(16'h03e8, 16'h03e8, 16'h03e8);
    @(posedge clk);
    blk <= 3'b000;
    wo(0, 3'b000, 10);
    $display("test block done");
  endtask
  task automatic t_group();
    w(8'h08, 32'h2);
    rc(8'h08, 32'h30000, 32'h10000);
    rc(8'h40, 32'hffff, 32'h0);
    w(8'h08, 32'h131);
    @(posedge clk);
    gsig <= 32'h1;
    rc(8'h08, 32'h30000, 32'h20000);
    @(posedge clk);
    gsig <= 32'h0;
    rc(8'h08, 32'h30000, 32'h0);
    $display("test group done");
  endtask
  task automatic t_force();
    w(8'h18, 32'h7f);
    w(8'h1c, 32'h40);
    chk({31'h0, irq}, 32'h0, "irq idle");
    w(8'h04, 32'h110);
    chk({29'h0, st}, 32'h0, "unforced write");
    w(8'h04, 32'h1);
    w(8'h04, 32'h111);
    wo(1, 3'b001, 4);
    chk({29'h0, st}, 32'h1, "forced start");
    wo(0, 3'b000, FMS * MS + 40);
    chk(n >= FMS * MS - 30, 1, "force kept");
    chk({31'h0, irq}, 32'h1, "irq expiry");
    w(8'h18, 32'h40);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    w(8'h00, 32'h0);
    rc(8'h00, 32'h1, 32'h0);
    $display("test force done");
  endtask
  initial begin
    rst = 1'b1;
    {wr, rd, adr, wdat, blk, gsig} = '0;
    {ab, bc, ca} = {3{16'h03e8}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_setup();
    t_trip();
    t_block();
    t_group();
    t_force();
    finish_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    $display("BAD %0t run time limit reached", $time);
    finish_test();
  end
endmodule // undervoltage_protection_stage_bench
`default_nettype wire
